// ---- verilog/lsd_pkg.sv ----
/*
 * Constants, command codes and state types of the LCD segment command decoder.
 * Assumes a single 20 MHz system clock and an active-low asynchronous reset.
 */
// Function
// R1: Display on/off command, nothing else changes.
// R2: Display off plus static drive means power save.
// R3: Start-line command loads 5-bit top line.
// R4: Shown rows run start line plus duty.
// R5: Page command selects page 0 to 3.
// R6: Page changes only host addressing.
// R7: Bit7 clear loads 7-bit column address.
// R8: Column increments saturate at 50 hex.
// R9: Status byte holds busy, order, off, init.
// R10: Busy while executing or initializing.
// R11: Host waits for busy low first.
// R12: Order bit 1 normal, 0 inverse.
// R13: Display status bit reads inverted.
// R14: Init bit set during initialization period.
// R15: Data write stores byte, column advances.
// R16: Data read advances column unless read-modify-write.
// R17: Host discards one dummy read first.
// R18: Order command bit0 selects inverse mapping.
// R19: Static drive forces whole display on.
// R20: Duty command selects 1/16 or 1/32.
// R21: Read-modify-write freezes column on reads.
// R22: End restores saved column, leaves mode.
// R23: Host avoids column set during that mode.
// R24: End command is byte EE hex.
// R25: Select and strobes choose the access type.
// R26: Reset command: start line 0, page 3.
// R27: Display on or static off exits save.
// R28: Reads return the holder, one access late.

`default_nettype none

package lsd_pkg;

   // ************************************************************
   // Geometry
   // ************************************************************
   localparam int         NUM_PAGES  = 4;
   localparam int         NUM_COLS   = 80;
   localparam int         RAM_BYTES  = NUM_PAGES * NUM_COLS;
   localparam int         NUM_SEGS   = 80;
   localparam int         FIFO_DEPTH = 16;
   localparam int         FIFO_WIDTH = 10;
   localparam logic [6:0] COL_LIMIT  = 7'h50;
   localparam logic [6:0] COL_LAST   = 7'h4f;
   localparam logic [4:0] HALF_LINES = 5'h10;

   // ************************************************************
   // Reset values
   // ************************************************************
   localparam logic [1:0] PAGE_RESET  = 2'h3;
   localparam logic [4:0] START_RESET = 5'h00;

   // ************************************************************
   // Timing
   // ************************************************************
   localparam int         CLK_PERIOD_NS = 50;
   localparam int         INIT_TIME_NS  = 1000;
   localparam int         EXEC_TIME_NS  = 100;
   localparam logic [4:0] INIT_CYCLES   =
      5'((INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [4:0] EXEC_CYCLES   =
      5'((EXEC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   // ************************************************************
   // Command codes and masks
   // ************************************************************
   localparam logic [7:0] OP_DISPLAY   = 8'hae;
   localparam logic [7:0] OP_ORDER     = 8'ha0;
   localparam logic [7:0] OP_STATIC    = 8'ha4;
   localparam logic [7:0] OP_DUTY      = 8'ha8;
   localparam logic [7:0] OP_RMW       = 8'he0;
   localparam logic [7:0] OP_END       = 8'hee;
   localparam logic [7:0] OP_RESET     = 8'he2;
   localparam logic [7:0] OP_PAGE      = 8'hb8;
   localparam logic [7:0] OP_START     = 8'hc0;
   localparam logic [7:0] MASK_FLAG    = 8'hfe;
   localparam logic [7:0] MASK_PAGE    = 8'hfc;
   localparam logic [7:0] MASK_START   = 8'he0;

   // ************************************************************
   // Queue entry kinds
   // ************************************************************
   localparam logic [1:0] KIND_CMD = 2'h0;
   localparam logic [1:0] KIND_WR  = 2'h1;
   localparam logic [1:0] KIND_RD  = 2'h2;

   // ************************************************************
   // Types
   // ************************************************************
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_EXEC = 2'h1,
      ST_INIT = 2'h2
   } lsd_state_t;

   typedef struct packed {
      logic                         rsS1;
      logic                         rsS2;
      logic                         rdS1;
      logic                         rdS2;
      logic                         rdS3;
      logic                         wrS1;
      logic                         wrS2;
      logic                         wrS3;
      logic [7:0]                   dS1;
      logic [7:0]                   dS2;
      lsd_state_t                   state;
      logic [4:0]                   waitCnt;
      logic                         displayOn;
      logic                         segInverse;
      logic                         staticOn;
      logic                         duty32;
      logic                         rmwOn;
      logic [4:0]                   startLine;
      logic [1:0]                   page;
      logic [6:0]                   column;
      logic [6:0]                   savedColumn;
      logic [7:0]                   holder;
      logic [7:0]                   readByte;
      logic                         dataOe;
      logic [RAM_BYTES-1:0][7:0]    ram;
      logic [NUM_SEGS-1:0]          segOut;
   } lsd_core_t;

   localparam lsd_core_t CORE_RESET = '{
      rdS1: 1'b1, rdS2: 1'b1, rdS3: 1'b1,
      wrS1: 1'b1, wrS2: 1'b1, wrS3: 1'b1,
      state: ST_INIT, waitCnt: INIT_CYCLES - 5'h01,
      page: PAGE_RESET, startLine: START_RESET,
      default: '0
   };

endpackage

`default_nettype wire

// ---- verilog/lsd_fifo.sv ----
/*
 * Synchronous FIFO with valid/ready on both sides, held in flip-flops.
 * Assumes DEPTH is a power of two and one clock for both sides.
 */
`timescale 1ns/1ps
`default_nettype none

module lsd_fifo #(
   parameter int WIDTH = 10,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input  wire logic             sys_clk,
   input  wire logic             rst_n,
   // Filling side
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inData,
   // Draining side
   output logic                  outValid,
   input  wire logic             outReady,
   output logic [WIDTH-1:0]      outData
);

   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wrPtr;
      logic [AW-1:0]               rdPtr;
      logic [AW:0]                 fill;
   } lsd_fifo_state_t;

   lsd_fifo_state_t q;
   lsd_fifo_state_t d;
   logic            push;
   logic            pop;

   assign inReady  = (q.fill != (AW + 1)'(DEPTH));
   assign outValid = (q.fill != '0);
   assign outData  = q.mem[q.rdPtr];
   assign push     = inValid & inReady;
   assign pop      = outValid & outReady;

   always_comb begin
      d = q;
      if (push) begin
         d.mem[q.wrPtr] = inData;
         d.wrPtr        = q.wrPtr + 1'b1;
      end
      if (pop) begin
         d.rdPtr = q.rdPtr + 1'b1;
      end
      d.fill = q.fill + (AW + 1)'(push) - (AW + 1)'(pop);
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

endmodule // lsd_fifo

`default_nettype wire

// ---- verilog/lsd_cmd_decoder.sv ----
/*
 * Host port, instruction decoder, display RAM and row scan of an 80-segment
 * bit-map LCD driver.
 * Assumes host pins arrive asynchronously and are synchronised here, and that
 * the frame logic supplies the common row being scanned on the system clock.
 */
`timescale 1ns/1ps
`default_nettype none

module lsd_cmd_decoder #(
   parameter int FIFO_DEPTH = lsd_pkg::FIFO_DEPTH
) (
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   // Host bus pins
   input  wire logic        registerSelect,
   input  wire logic        rd_n,
   input  wire logic        wr_n,
   input  wire logic [7:0]  dataIn,
   output logic      [7:0]  dataOut,
   output logic             dataOe,
   // Row scan from the frame logic
   input  wire logic [4:0]  comRow,
   output logic      [4:0]  scanLine,
   output logic             rowActive,
   output logic      [79:0] segOut,
   // Mode outputs
   output logic             displayOn,
   output logic             staticDrive,
   output logic             segInverse,
   output logic             duty32,
   output logic             powerSave,
   output logic             busy,
   output logic             initActive
);

   // ************************************************************
   // Helper functions
   // ************************************************************

   // Byte index of a page and column in the flat display RAM.
   function automatic logic [8:0] ramIdx(input logic [1:0] pg, input logic [6:0] col);
      ramIdx = 9'({7'h00, pg} * {2'h0, lsd_pkg::COL_LIMIT}) + {2'h0, col};
   endfunction

   // Next column after an access, held at the limit.
   function automatic logic [6:0] colNext(input logic [6:0] col);
      colNext = (col == lsd_pkg::COL_LIMIT) ? col : col + 7'h01; // R8
   endfunction

   // ************************************************************
   // State and wiring
   // ************************************************************
   lsd_pkg::lsd_core_t q;
   lsd_pkg::lsd_core_t d;

   logic       wrRise;
   logic       rdFall;
   logic       qInValid;
   logic       qInReady;
   logic [9:0] qInData;
   logic       qOutValid;
   logic       qOutReady;
   logic [9:0] qOutData;
   logic [1:0] opKind;
   logic [7:0] opByte;
   logic [7:0] statusByte;
   logic [4:0] lineNow;
   logic       rowOn;
   logic       saveNow;

   // ************************************************************
   // Host strobe edges
   // ************************************************************

   // A write is taken at the end of its strobe, a read at its start.
   assign wrRise = q.wrS2 & ~q.wrS3;
   assign rdFall = ~q.rdS2 & q.rdS3;

   // Writes and data reads are queued in order; status reads are not.
   assign qInValid = wrRise | (rdFall & q.rsS2);
   assign qInData  = wrRise ? {(q.rsS2 ? lsd_pkg::KIND_WR : lsd_pkg::KIND_CMD), q.dS2}
                            : {lsd_pkg::KIND_RD, 8'h00}; // R25

   // ************************************************************
   // Command queue
   // ************************************************************
   lsd_fifo #(
      .WIDTH (lsd_pkg::FIFO_WIDTH),
      .DEPTH (FIFO_DEPTH)
   ) u_queue (
      .sys_clk  (sys_clk),
      .rst_n    (rst_n),
      .inValid  (qInValid),
      .inReady  (qInReady),
      .inData   (qInData),
      .outValid (qOutValid),
      .outReady (qOutReady),
      .outData  (qOutData)
   );

   // The executor only drains the queue while idle, so a burst fills it.
   assign qOutReady = (q.state == lsd_pkg::ST_IDLE);
   assign opKind    = qOutData[9:8];
   assign opByte    = qOutData[7:0];

   // ************************************************************
   // Status
   // ************************************************************

   // Busy covers queued work, a full queue, execution and initialization.
   assign busy = qOutValid | ~qInReady | (q.state != lsd_pkg::ST_IDLE); // R10 R11

   assign initActive = (q.state == lsd_pkg::ST_INIT); // R14

   assign statusByte = {busy, ~q.segInverse, ~q.displayOn, initActive, 4'h0}; // R9 R12 R13

   // ************************************************************
   // Row scan
   // ************************************************************

   // The row shown on a common is the start line plus the row, wrapping.
   assign lineNow = 5'(q.startLine + comRow); // R3 R4
   assign rowOn   = q.duty32 | (comRow < lsd_pkg::HALF_LINES); // R4 R20

   assign saveNow = ~q.displayOn & q.staticOn; // R2 R27

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb begin
      d = q;

      // Two-flop synchronisers on every host pin.
      d.rsS1 = registerSelect;
      d.rsS2 = q.rsS1;
      d.rdS1 = rd_n;
      d.rdS2 = q.rdS1;
      d.rdS3 = q.rdS2;
      d.wrS1 = wr_n;
      d.wrS2 = q.wrS1;
      d.wrS3 = q.wrS2;
      d.dS1  = dataIn;
      d.dS2  = q.dS1;

      // Read answer: status at once, data from the holder left by the last read, write or column set.
      d.dataOe = ~q.rdS2;
      if (rdFall) begin
         if (q.rsS2) begin
            d.readByte = q.holder; // R28 R17
         end else begin
            d.readByte = statusByte; // R9
         end
      end

      case (q.state)
         lsd_pkg::ST_IDLE: begin
            if (qOutValid) begin
               d.state   = lsd_pkg::ST_EXEC;
               d.waitCnt = lsd_pkg::EXEC_CYCLES - 5'h01;
               case (opKind)
                  lsd_pkg::KIND_WR: begin
                     if (q.column != lsd_pkg::COL_LIMIT) begin
                        d.ram[ramIdx(q.page, q.column)] = opByte; // R15
                     end
                     d.holder = opByte; // R28
                     d.column = colNext(q.column); // R15 R21
                  end
                  lsd_pkg::KIND_RD: begin
                     if (q.column != lsd_pkg::COL_LIMIT) begin
                        d.holder = q.ram[ramIdx(q.page, q.column)]; // R28
                     end
                     if (!q.rmwOn) begin
                        d.column = colNext(q.column); // R16
                     end
                  end
                  lsd_pkg::KIND_CMD: begin
                     if (!opByte[7]) begin
                        d.column = opByte[6:0]; // R7
                        d.holder = opByte; // R28
                     end else if ((opByte & lsd_pkg::MASK_FLAG) == lsd_pkg::OP_DISPLAY) begin
                        d.displayOn = opByte[0]; // R1 R27
                     end else if ((opByte & lsd_pkg::MASK_START) == lsd_pkg::OP_START) begin
                        d.startLine = opByte[4:0]; // R3
                     end else if ((opByte & lsd_pkg::MASK_PAGE) == lsd_pkg::OP_PAGE) begin
                        d.page = opByte[1:0]; // R5 R6
                     end else if ((opByte & lsd_pkg::MASK_FLAG) == lsd_pkg::OP_ORDER) begin
                        d.segInverse = opByte[0]; // R18
                     end else if ((opByte & lsd_pkg::MASK_FLAG) == lsd_pkg::OP_STATIC) begin
                        d.staticOn = opByte[0]; // R19 R27
                     end else if ((opByte & lsd_pkg::MASK_FLAG) == lsd_pkg::OP_DUTY) begin
                        d.duty32 = opByte[0]; // R20
                     end else if (opByte == lsd_pkg::OP_RMW) begin
                        d.rmwOn       = 1'b1; // R21
                        d.savedColumn = q.column; // R22
                     end else if (opByte == lsd_pkg::OP_END) begin // R24
                        if (q.rmwOn) begin
                           d.column = q.savedColumn; // R22
                        end
                        d.rmwOn = 1'b0; // R22
                     end else if (opByte == lsd_pkg::OP_RESET) begin
                        d.startLine = lsd_pkg::START_RESET; // R26
                        d.page      = lsd_pkg::PAGE_RESET; // R26
                        d.state     = lsd_pkg::ST_INIT; // R14
                        d.waitCnt   = lsd_pkg::INIT_CYCLES - 5'h01;
                     end
                  end
                  default: begin
                     d.state = lsd_pkg::ST_EXEC;
                  end
               endcase
            end
         end
         lsd_pkg::ST_EXEC,
         lsd_pkg::ST_INIT: begin
            if (q.waitCnt == 5'h00) begin
               d.state = lsd_pkg::ST_IDLE; // R10
            end else begin
               d.waitCnt = q.waitCnt - 5'h01;
            end
         end
         default: begin
            d.state = lsd_pkg::ST_IDLE;
         end
      endcase

      // Segment pattern for the row being scanned.
      for (int n = 0; n < lsd_pkg::NUM_SEGS; n++) begin
         if (saveNow) begin
            d.segOut[n] = 1'b0; // R2
         end else if (q.staticOn) begin
            d.segOut[n] = 1'b1; // R19
         end else if (!q.displayOn || !rowOn) begin
            d.segOut[n] = 1'b0; // R1 R4
         end else if (q.segInverse) begin
            d.segOut[n] = q.ram[ramIdx(lineNow[4:3],
                                       lsd_pkg::COL_LAST - 7'(n))][lineNow[2:0]]; // R12
         end else begin
            d.segOut[n] = q.ram[ramIdx(lineNow[4:3], 7'(n))][lineNow[2:0]]; // R12
         end
      end
   end

   // ************************************************************
   // Registers
   // ************************************************************
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= lsd_pkg::CORE_RESET; // R14
      end else begin
         q <= d;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   assign dataOut     = q.readByte;
   assign dataOe      = q.dataOe;
   assign scanLine    = lineNow;
   assign rowActive   = rowOn;
   assign segOut      = q.segOut;
   assign displayOn   = q.displayOn;
   assign staticDrive = q.staticOn;
   assign segInverse  = q.segInverse;
   assign duty32      = q.duty32;
   assign powerSave   = saveNow;

endmodule // lsd_cmd_decoder

`default_nettype wire

// ---- test/lsd_cmd_checker.sv ----
/* Port assertions of the command decoder, bound into every instance.
   Assumes one clock, sys_clk, and the active-low reset rst_n. */
`timescale 1ns/1ps
`default_nettype none

module lsd_cmd_checker (
   // Clock and reset
   input wire logic        sys_clk,
   input wire logic        rst_n,
   // Host bus
   input wire logic        registerSelect,
   input wire logic        rd_n,
   input wire logic [7:0]  dataOut,
   input wire logic        dataOe,
   // Row scan
   input wire logic [4:0]  comRow,
   input wire logic        rowActive,
   input wire logic [79:0] segOut,
   // Modes
   input wire logic        displayOn,
   input wire logic        staticDrive,
   input wire logic        segInverse,
   input wire logic        duty32,
   input wire logic        powerSave,
   input wire logic        busy,
   input wire logic        initActive
);
   // ************************************************************
   // Properties
   // ************************************************************
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   AST_POWER_SAVE: assert property (powerSave == (!displayOn && staticDrive))
      else $error("power save flag disagrees with mode flags");
   AST_ROW_ACTIVE: assert property (rowActive == (duty32 || comRow < 5'h10))
      else $error("row active disagrees with duty and row");
   AST_STATIC_ON: assert property ($past(staticDrive) && $past(displayOn) |-> segOut == '1)
      else $error("static drive did not light all segments");
   AST_SAVE_BLANK: assert property ($past(powerSave) |-> segOut == '0)
      else $error("segments lit in power save");
   AST_OFF_BLANK: assert property (!$past(displayOn) && !$past(staticDrive) |-> segOut == '0)
      else $error("segments lit with display off");
   AST_ROW_BLANK: assert property (!$past(rowActive) && !$past(staticDrive) |-> segOut == '0)
      else $error("segments lit on a row outside the duty");
   AST_INIT_BUSY: assert property (initActive |-> busy)
      else $error("busy low during initialization");
   AST_READ_ENABLE: assert property (!rd_n [*6] |-> dataOe)
      else $error("bus not driven during a read");
   AST_READ_RELEASE: assert property (rd_n [*6] |-> !dataOe)
      else $error("bus still driven after a read");
   AST_STATUS_LOW: assert property ((!registerSelect && !rd_n) [*6] |-> dataOut[3:0] == 4'h0)
      else $error("status low nibble not zero");
   AST_STATUS_FLAGS: assert property ((!registerSelect && !rd_n && !busy) [*6]
      |-> dataOut[7:5] == {1'b0, !segInverse, !displayOn})
      else $error("status flags disagree with mode outputs");
endmodule // lsd_cmd_checker

bind lsd_cmd_decoder lsd_cmd_checker u_chk (.sys_clk(sys_clk), .rst_n(rst_n),
   .registerSelect(registerSelect), .rd_n(rd_n), .dataOut(dataOut), .dataOe(dataOe),
   .comRow(comRow), .rowActive(rowActive), .segOut(segOut), .displayOn(displayOn),
   .staticDrive(staticDrive), .segInverse(segInverse), .duty32(duty32),
   .powerSave(powerSave), .busy(busy), .initActive(initActive));

`default_nettype wire

// ---- test/lsd_host_model.sv ----
/* Host processor model that drives the decoder's bus pins.
   Assumes its tasks are called at a falling edge of sys_clk. */
`timescale 1ns/1ps
`default_nettype none

module lsd_host_model (
   // Clock
   input  wire logic       sys_clk,
   // Bus pins
   output var logic        registerSelect,
   output var logic        rd_n,
   output var logic        wr_n,
   output var logic [7:0]  dataIn,
   input  wire logic [7:0] dataOut
);
   // ************************************************************
   // Bus cycles
   // ************************************************************
   int hangs = 0;
   int gap = 0;

   initial begin
      registerSelect = 1'b0;
      rd_n = 1'b1;
      wr_n = 1'b1;
      dataIn = 8'h00;
   end

   // Select and data settle before the strobe and stay after it; a freed bus flips.
   task automatic access(input logic sel, input logic rd, input logic [7:0] d,
                         output logic [7:0] q);
      registerSelect = sel;
      dataIn = rd ? ~dataIn : d;
      repeat (3 + gap) @(negedge sys_clk);
      if (rd) rd_n = 1'b0;
      else wr_n = 1'b0;
      repeat (6) @(negedge sys_clk);
      q = dataOut;
      rd_n = 1'b1;
      wr_n = 1'b1;
      repeat (2) @(negedge sys_clk);
      dataIn = ~dataIn;
      repeat (2) @(negedge sys_clk);
   endtask

   task automatic waitReady();
      logic [7:0] s;
      int         n;
      s = 8'h80;
      for (n = 0; n < 40 && s[7] !== 1'b0; n++) access(1'b0, 1'b1, 8'h00, s);
      if (s[7] !== 1'b0) hangs++;
   endtask

   task automatic op(input logic sel, input logic rd, input logic [7:0] d,
                     output logic [7:0] q);
      waitReady();
      access(sel, rd, d, q);
   endtask
endmodule // lsd_host_model

`default_nettype wire

// ---- test/test_lsd_cmd_decoder.sv ----
/* Self-checking bench of the command decoder with a host model on its bus.
   Assumes the checker is bound in and the clock runs at 20 MHz. */
`timescale 1ns/1ps
`default_nettype none

module test_lsd_cmd_decoder;
   // ************************************************************
   // Signals, model state and helpers
   // ************************************************************
   logic        sys_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        registerSelect, rd_n, wr_n, dataOe, rowActive, busy, initActive;
   logic        displayOn, staticDrive, segInverse, duty32, powerSave, rmw;
   logic [7:0]  dataIn, dataOut, q, holder;
   logic [4:0]  comRow = 5'h00;
   logic [4:0]  scanLine, s;
   logic [79:0] segOut;
   logic [7:0]  ram [4][80];
   logic [6:0]  col, savedCol, c;
   logic [1:0]  pg;
   logic [7:0]  flagOps [4] = '{8'hae, 8'ha0, 8'ha4, 8'ha8};
   logic [7:0]  saveOps [5] = '{8'haf, 8'ha5, 8'hae, 8'haf, 8'ha4};
   int          failures = 0;
   int          samples_checked = 0;
   int          seed = 87192;
   int          i, j;

   always #25 sys_clk = ~sys_clk;

   lsd_host_model host (.sys_clk(sys_clk), .registerSelect(registerSelect), .rd_n(rd_n),
      .wr_n(wr_n), .dataIn(dataIn), .dataOut(dataOut));
   lsd_cmd_decoder dut (.sys_clk(sys_clk), .rst_n(rst_n), .registerSelect(registerSelect),
      .rd_n(rd_n), .wr_n(wr_n), .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe),
      .comRow(comRow), .scanLine(scanLine), .rowActive(rowActive), .segOut(segOut),
      .displayOn(displayOn), .staticDrive(staticDrive), .segInverse(segInverse),
      .duty32(duty32), .powerSave(powerSave), .busy(busy), .initActive(initActive));

   function automatic logic [7:0] statusExp(input logic inv, input logic on);
      return {1'b0, !inv, !on, 5'h00};
   endfunction

   task automatic check(input logic [79:0] seen, input logic [79:0] want);
      samples_checked++;
      if (seen !== want) begin
         failures++;
         $display("unexpected at %0t: saw %0h, wanted %0h", $time, seen, want);
      end
   endtask

   task automatic results();
      if (failures == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // Waits for busy low, then one host access; the model tracks address, holder and memory to predict reads.
   task automatic bus(input logic sel, input logic rd, input logic [7:0] d);
      host.op(sel, rd, d, q);
      if (sel && rd) begin
         check(q, holder);
         if (col < 7'h50) holder = ram[pg][col];
         if (col < 7'h50 && !rmw) col++;
      end else if (sel) begin
         holder = d;
         if (col < 7'h50) begin
            ram[pg][col] = d;
            col++;
         end
      end else if (!d[7]) begin
         col = d[6:0];
         holder = d;
      end else if (d[7:2] == 6'b101110) pg = d[1:0];
      else if (d == 8'he0) begin
         rmw = 1'b1;
         savedCol = col;
      end else if (d == 8'hee) begin
         if (rmw) col = savedCol;
         rmw = 1'b0;
      end else if (d == 8'he2) pg = 2'h3;
   endtask

   initial begin
      repeat (90000) @(posedge sys_clk);
      failures++;
      results();
   end

   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      foreach (ram[a, b]) ram[a][b] = 8'h00;
      {holder, col, savedCol, pg, rmw} = {8'h00, 7'h00, 7'h00, 2'h3, 1'b0};
      repeat (4) @(negedge sys_clk);
      rst_n = 1'b1;
      @(negedge sys_clk);
      check(busy & initActive, 1'b1);
      host.waitReady();
      host.access(1'b0, 1'b1, 8'h00, q);
      check(q, statusExp(1'b0, 1'b0));
      comRow = 5'h14;
      for (i = 0; i < 8; i++) begin
         bus(1'b0, 1'b0, flagOps[i / 2] | 8'(~i & 1));
         host.waitReady();
         check({displayOn, segInverse, staticDrive, duty32},
               4'(~i & 1) << (3 - i / 2));
         check(powerSave, i == 4);
         check(rowActive, i == 6);
         host.access(1'b0, 1'b1, 8'h00, q);
         check(q, statusExp(i == 2, i == 0));
      end
      for (i = 0; i < 5; i++) begin
         bus(1'b0, 1'b0, saveOps[i]);
         host.waitReady();
         check(powerSave, i == 2);
      end
      for (i = 0; i < 4; i++) begin
         s = 5'($random(seed));
         comRow = 5'($random(seed));
         bus(1'b0, 1'b0, {3'b110, s});
         host.waitReady();
         check(scanLine, 5'(s + comRow));
      end
      for (i = 0; i < 3; i++) begin
         host.gap = $random(seed) & 3;
         c = 7'($unsigned($random(seed)) % 76);
         bus(1'b0, 1'b0, {6'b101110, 2'($random(seed))});
         bus(1'b0, 1'b0, {1'b0, c});
         for (j = 0; j < 4; j++) bus(1'b1, 1'b0, 8'($random(seed)));
         bus(1'b0, 1'b0, {1'b0, c});
         for (j = 0; j < 5; j++) bus(1'b1, 1'b1, 8'h00);
      end
      bus(1'b0, 1'b0, 8'h4f);
      bus(1'b1, 1'b0, 8'h5a);
      bus(1'b1, 1'b0, 8'ha5);
      bus(1'b0, 1'b0, 8'h4f);
      for (j = 0; j < 3; j++) bus(1'b1, 1'b1, 8'h00);
      bus(1'b0, 1'b0, 8'h10);
      bus(1'b0, 1'b0, 8'he0);
      for (j = 0; j < 3; j++) bus(1'b1, 1'b1, 8'h00);
      bus(1'b0, 1'b0, 8'hb9);
      bus(1'b1, 1'b0, 8'h3c);
      bus(1'b0, 1'b0, 8'hee);
      for (j = 0; j < 2; j++) bus(1'b1, 1'b1, 8'h00);
      bus(1'b0, 1'b0, 8'hc5);
      bus(1'b0, 1'b0, 8'he2);
      for (j = 0; j < 20 && initActive !== 1'b1; j++) @(negedge sys_clk);
      check(initActive, 1'b1);
      comRow = 5'h07;
      host.waitReady();
      check(scanLine, 5'h07);
      bus(1'b0, 1'b0, 8'h00);
      for (j = 0; j < 2; j++) bus(1'b1, 1'b1, 8'h00);
      bus(1'b0, 1'b0, 8'hb8);
      bus(1'b0, 1'b0, 8'h00);
      bus(1'b1, 1'b0, 8'h01);
      comRow = 5'h00;
      host.waitReady();
      check(segOut[0], 1'b1);
      bus(1'b0, 1'b0, 8'ha1);
      host.waitReady();
      check(segOut[79], 1'b1);
      bus(1'b0, 1'b0, 8'hba);
      host.waitReady();
      check(segOut[79], 1'b1);
      check(host.hangs, 0);
      results();
   end
endmodule // test_lsd_cmd_decoder

`default_nettype wire
